// file: sim/cycle_timer_status_flags_chk.sv
// Port checks of the cycle timer status flag block.
// Assumes one clock and a synchronous reset; attached by the bind below.
`timescale 1ns/1ns
`default_nettype none
module cycle_timer_status_flags_chk (
	// Clock, reset and bus.
	input wire logic clk,
	input wire logic reset,
	input wire logic [4:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [31:0] readdata,
	input wire logic waitrequest,
	// Observation.
	input wire cycle_timer_pkg::flags_s flags,
	input wire logic [15:0] capture_register
);
	import cycle_timer_pkg::*;
	logic [7:0] armed;
	logic speed;
	logic [15:0] lim;
	logic done;
	// Completed accesses, and what software last read or wrote.
	assign done = !waitrequest;
	always_ff @(posedge clk) begin
		if (reset) begin
			armed <= 8'h00;
			speed <= 1'b0;
			lim <= LIMIT_RESET;
		end else begin
			if (write && done && address == STATUS_OFFSET) armed <= 8'h00;
			else if (read && done && address == STATUS_OFFSET) armed <= readdata[7:0];
			if (write && done && address == CONFIG_OFFSET) speed <= writedata[SPEED_MODE_BIT];
			if (write && done && address == LIMIT_OFFSET) lim <= writedata[15:0];
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	property p_wait;
		$rose(read || write) |-> waitrequest ##1 !waitrequest;
	endproperty
	a_wait: assert property (p_wait) else $error("waitrequest timing");
	property p_clr_wrap;
		$fell(flags.wrap) |-> $past(write && done && address == STATUS_OFFSET &&
			armed[WRAP_BIT] && !writedata[WRAP_BIT]);
	endproperty
	a_clr_wrap: assert property (p_clr_wrap) else $error("wrap cleared");
	property p_clr_ovf;
		$fell(flags.period_ovf) |-> $past(write && done && address == STATUS_OFFSET &&
			armed[PERIOD_OVF_BIT] && !writedata[PERIOD_OVF_BIT]);
	endproperty
	a_clr_ovf: assert property (p_clr_ovf) else $error("overflow cleared");
	property p_clr_cmp;
		$fell(flags.compare) |-> $past(write && done && address == STATUS_OFFSET &&
			armed[COMPARE_BIT] && !writedata[COMPARE_BIT]);
	endproperty
	a_clr_cmp: assert property (p_clr_cmp) else $error("compare cleared");
	property p_clr_cap;
		$fell(flags.capture) |-> $past(write && done && address == STATUS_OFFSET &&
			armed[CAPTURE_BIT] && !writedata[CAPTURE_BIT]);
	endproperty
	a_clr_cap: assert property (p_clr_cap) else $error("capture cleared");
	property p_no_cmp;
		$rose(flags.compare) |-> !$past(speed);
	endproperty
	a_no_cmp: assert property (p_no_cmp) else $error("compare in speed mode");
	property p_ovf;
		$changed(capture_register) && $past(speed) && capture_register > $past(lim)
			|-> flags.period_ovf;
	endproperty
	a_ovf: assert property (p_ovf) else $error("overflow missed");
	property p_ovf_why;
		$rose(flags.period_ovf) |-> $past(speed) && capture_register > $past(lim);
	endproperty
	a_ovf_why: assert property (p_ovf_why) else $error("overflow unfounded");
	property p_cap;
		$changed(capture_register) |-> flags.capture;
	endproperty
	a_cap: assert property (p_cap) else $error("capture flag missed");
	property p_resv;
		read && done && address == STATUS_OFFSET |-> readdata[2:0] == 3'h0;
	endproperty
	a_resv: assert property (p_resv) else $error("reserved bits");
	c_ovf: cover property ($rose(flags.period_ovf));
	c_cmp: cover property ($fell(flags.compare));
	c_cap: cover property ($rose(flags.capture));
endmodule
bind cycle_timer_status_flags cycle_timer_status_flags_chk cycle_timer_status_flags_chk_i (
	.clk(clk), .reset(reset), .address(address), .read(read), .write(write),
	.writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
	.flags(flags), .capture_register(capture_register)
);
`default_nettype wire

// file: sim/tach_model.sv
// Fan tachometer pulses and an external count clock for the bench.
// Assumes the bench clock; both pins hold their level while disabled.
`timescale 1ns/1ns
`default_nettype none
module tach_model #(parameter int HALF = 32) (
	// Clock and controls.
	input wire logic clk,
	input wire logic ev_en,
	input wire logic ck_en,
	// Pins.
	output logic event_input = 1'b0,
	output logic ext_clock = 1'b0
);
	int n = 0;
	logic [1:0] m = 2'h0;
	// Square waves that run only while enabled, so edge counts are exact.
	always @(posedge clk) begin
		n <= (ev_en && n < HALF - 1) ? n + 1 : 0;
		if (ev_en && n == HALF - 1) event_input <= ~event_input;
		m <= ck_en ? m + 2'h1 : 2'h0;
		if (ck_en && m == 2'h3) ext_clock <= ~ext_clock;
	end
endmodule
`default_nettype wire

// file: sim/test_cycle_timer_status_flags.sv
// Self-checking bench for the cycle timer status flag block.
// Assumes the tach model on the pins; the bench is the Avalon-MM master.
`timescale 1ns/1ns
`default_nettype none
module test_cycle_timer_status_flags;
	import cycle_timer_pkg::*;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic [4:0] address = 5'h00;
	logic read = 1'b0;
	logic write = 1'b0;
	logic [31:0] writedata = '0;
	logic [31:0] readdata;
	logic waitrequest;
	logic prescale_tick = 1'b1;
	logic ev_en = 1'b0;
	logic ck_en = 1'b0;
	logic event_input;
	logic ext_clock;
	flags_s flags;
	logic [15:0] capture_register;
	logic [31:0] q;
	int failures = 0;
	int n_compared = 0;
	int nr = 0;
	int nf = 0;
	// Clock, and a count of each kind of external clock edge.
	always #10 clk = ~clk;
	always @(posedge ext_clock) nr++;
	always @(negedge ext_clock) nf++;
	cycle_timer_status_flags cycle_timer_status_flags_i (
		.clk(clk), .reset(reset), .address(address), .read(read), .write(write),
		.writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
		.prescale_tick(prescale_tick), .ext_clock(ext_clock), .event_input(event_input),
		.flags(flags), .capture_register(capture_register)
	);
	tach_model tach_model_i (.clk(clk), .ev_en(ev_en), .ck_en(ck_en),
		.event_input(event_input), .ext_clock(ext_clock));
	////////////////////////////////////////////////////////////////////////
	// Prints the counts and the verdict, then stops.
	task automatic results();
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			failures++;
			$display("Error %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic tmo(input int n);
		if (n >= 400) begin
			failures++;
			results();
		end
	endtask
	// One Avalon-MM access; read data lands in q.
	task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		address <= a;
		read <= !w;
		write <= w;
		writedata <= d;
		do begin
			@(negedge clk);
			n++;
		end while (waitrequest !== 1'b0 && n < 400);
		tmo(n);
		@(posedge clk);
		q = readdata;
		read <= 1'b0;
		write <= 1'b0;
		@(negedge clk);
	endtask
	// Software clear: read the status, then write zero to it.
	task automatic clr();
		bus(1'b0, STATUS_OFFSET, '0);
		bus(1'b1, STATUS_OFFSET, '0);
	endtask
	task automatic waitf();
		int n;
		n = 0;
		while (flags.capture !== 1'b1 && n < 400) begin
			@(negedge clk);
			n++;
		end
		tmo(n);
	endtask
	task automatic t_reset();
		bus(1'b0, STATUS_OFFSET, '0);
		chk("status", {24'h00_0000, STATUS_RESET}, q);
		bus(1'b0, LIMIT_OFFSET, '0);
		chk("limit", {16'h0000, LIMIT_RESET}, q);
		bus(1'b0, 5'h14, '0);
		chk("unmapped", '0, q);
	endtask
	task automatic t_compare();
		bus(1'b1, LIMIT_OFFSET, 32'h0000_0040);
		bus(1'b1, CONFIG_OFFSET, 32'h0000_0001);
		repeat (80) @(negedge clk);
		chk("compare set", 1'b1, flags.compare);
		bus(1'b0, STATUS_OFFSET, '0);
		bus(1'b1, STATUS_OFFSET, 32'h0000_00f8);
		chk("compare after ones", 1'b1, flags.compare);
		bus(1'b1, STATUS_OFFSET, '0);
		chk("compare unread", 1'b1, flags.compare);
		clr();
		chk("compare clear", 1'b0, flags.compare);
	endtask
	task automatic t_wrap();
		bus(1'b1, COUNTER_OFFSET, 32'h0000_fff0);
		repeat (30) @(negedge clk);
		chk("wrap set", 1'b1, flags.wrap);
		clr();
		chk("wrap clear", 1'b0, flags.wrap);
	endtask
	// External clock: only the selected edge kind advances the counter.
	task automatic t_ext();
		logic [31:0] c;
		int r;
		int f;
		for (int e = 1; e >= 0; e--) begin
			bus(1'b1, CONFIG_OFFSET, 32'h0000_0071);
			bus(1'b1, STATUS_OFFSET, e << EXT_EDGE_BIT);
			bus(1'b0, COUNTER_OFFSET, '0);
			c = q;
			r = nr;
			f = nf;
			@(posedge clk);
			ck_en <= 1'b1;
			repeat (36) @(posedge clk);
			ck_en <= 1'b0;
			repeat (10) @(posedge clk);
			bus(1'b0, COUNTER_OFFSET, '0);
			chk("ext count", c + (e ? nr - r : nf - f), q);
		end
	endtask
	// Timer capture for every edge select and polarity pair.
	task automatic t_cap();
		@(posedge clk);
		ev_en <= 1'b1;
		for (int k = 0; k < 4; k++) begin
			bus(1'b1, CONFIG_OFFSET, 32'h0000_0001 | (k << 2));
			repeat (5) @(posedge clk);
			clr();
			waitf();
			chk("edge level", !(k[0] ^ k[1]), event_input);
			bus(1'b1, STATUS_OFFSET, 32'h0000_00f8);
			chk("capture kept", 1'b1, flags.capture);
		end
	endtask
	task automatic meas();
		clr();
		waitf();
		clr();
		waitf();
	endtask
	// Speed mode: two input periods of 64 cycles form one measurement.
	task automatic t_speed();
		bus(1'b1, CONFIG_OFFSET, 32'h0000_0003);
		bus(1'b1, LIMIT_OFFSET, 32'h0000_00c8);
		meas();
		chk("period", 1'b1, capture_register >= 16'h007e && capture_register <= 16'h0081);
		chk("no overflow", 1'b0, flags.period_ovf);
		bus(1'b1, LIMIT_OFFSET, 32'h0000_0032);
		meas();
		chk("overflow", 1'b1, flags.period_ovf);
		chk("no compare", 1'b0, flags.compare);
		@(posedge clk);
		ev_en <= 1'b0;
	endtask
	initial begin
		repeat (12) @(posedge clk);
		reset <= 1'b0;
		t_reset();
		t_compare();
		t_wrap();
		t_ext();
		t_cap();
		t_speed();
		results();
	end
endmodule
`default_nettype wire

// file: verilog/cycle_timer_pkg.sv
// Constants, field layouts and carriers for the cycle timer status flag block.
// Assumes a 50 MHz system clock and an Avalon-MM master with 32-bit data.
//
// What this block does
// - In speed measurement mode the period-limit overflow flag is set when the captured count exceeds the cycle limit.
// - The period-limit overflow flag clears only after software reads it as 1 and then writes 0 to it.
// - In timer mode the compare-match flag is set whenever the counter equals the cycle limit register.
// - In speed measurement mode the compare-match flag is never set, even on equal values.
// - The compare-match flag clears only by a read as 1 followed by a write of 0.
// - With the external clock selected, falling edges count when the edge select bit is 0 and rising edges when it is 1.
// - In timer mode, while running, the selected event edge copies the counter into the capture register and sets the capture flag.
// - In speed measurement mode the third selected edge of a period copies the counter and sets the capture flag.
// - The capture flag clears only by a read as 1 followed by a write of 0 and stays set after any other access.
// - A software write of 1 to any flag is ignored; a write of 0 can only clear it.
// - The three low reserved status bits reset to zero and software keeps them at zero.
// - The counter wrap flag is set when the counter rolls from its maximum to zero and clears like the others.
// - At the third-edge capture the captured count is compared with the cycle limit to form the overflow condition.
// - Without polarity inversion the event rising edge is used for select 0 and falling for 1; inversion swaps them.
package cycle_timer_pkg;

	// Register byte offsets on the Avalon-MM port.
	localparam logic [4:0] STATUS_OFFSET = 5'h00;
	localparam logic [4:0] CONFIG_OFFSET = 5'h04;
	localparam logic [4:0] LIMIT_OFFSET = 5'h08;
	localparam logic [4:0] CAPTURE_OFFSET = 5'h0c;
	localparam logic [4:0] COUNTER_OFFSET = 5'h10;

	// Status register bit positions.
	localparam int WRAP_BIT = 7;
	localparam int PERIOD_OVF_BIT = 6;
	localparam int COMPARE_BIT = 5;
	localparam int EXT_EDGE_BIT = 4;
	localparam int CAPTURE_BIT = 3;

	// Configuration register bit positions.
	localparam int RUN_BIT = 0;
	localparam int SPEED_MODE_BIT = 1;
	localparam int EVENT_EDGE_BIT = 2;
	localparam int POLARITY_BIT = 3;
	localparam int CLOCK_SEL_LSB = 4;

	// Reset values and codes.
	localparam logic [15:0] LIMIT_RESET = 16'hffff;
	localparam logic [15:0] COUNT_RESET = 16'h0000;
	localparam logic [15:0] COUNT_MAX = 16'hffff;
	localparam logic [7:0] STATUS_RESET = 8'h00;
	localparam logic [2:0] CLOCK_SEL_EXTERNAL = 3'h7;

	// Sticky flags held in the status register.
	typedef struct packed {
		logic wrap;
		logic period_ovf;
		logic compare;
		logic capture;
	} flags_s;

	// Software configuration that steers the counting logic.
	typedef struct packed {
		logic run;
		logic speed_mode;
		logic event_edge_select;
		logic event_polarity_invert;
		logic [2:0] clock_select;
	} config_s;

	// Progress through a speed measurement period.
	typedef enum logic [1:0] {
		meas_idle,
		meas_first,
		meas_second
	} meas_state_e;

endpackage

// file: verilog/cycle_timer_status_flags.sv
// Counter, capture and sticky status flags of one cycle measurement channel.
// Assumes an Avalon-MM master, a prescaler tick on the system clock and raw pins.
`timescale 1ns/1ns
`default_nettype none
module cycle_timer_status_flags (
	// Clock and reset.
	input wire logic clk,
	input wire logic reset,
	// Avalon-MM slave.
	input wire logic [4:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	output logic [31:0] readdata,
	output logic waitrequest,
	// Counting sources.
	input wire logic prescale_tick,
	input wire logic ext_clock,
	input wire logic event_input,
	// Flag and capture observation.
	output var cycle_timer_pkg::flags_s flags,
	output logic [15:0] capture_register
);
	import cycle_timer_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// Pin conditioning.

	logic ext_rise;
	logic ext_fall;
	logic event_rise;
	logic event_fall;

	// Each pin crosses two flip-flops before any edge logic looks at it.
	// An edge therefore reaches the counting logic two cycles after the pin moves.
	// External counter clock pin.
	pin_edge_detect ext_sync (
		.clk(clk),
		.reset(reset),
		.pin(ext_clock),
		.rise(ext_rise),
		.fall(ext_fall)
	);

	// Event input pin from the fan tachometer.
	pin_edge_detect event_sync (
		.clk(clk),
		.reset(reset),
		.pin(event_input),
		.rise(event_rise),
		.fall(event_fall)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Bus handshake.

	logic ack;
	logic next_ack;
	logic [31:0] next_readdata;
	logic status_read;
	logic status_write;
	logic config_write;
	logic limit_write;
	logic counter_write;

	// Registers written by software.
	config_s cfg;
	config_s next_cfg;
	logic [15:0] cycle_limit_register;
	logic [15:0] next_cycle_limit_register;
	logic ext_clock_edge_select;
	logic next_ext_clock_edge_select;
	logic [15:0] period_counter;

	// Read-as-one arming per flag.
	flags_s armed;
	flags_s next_armed;
	flags_s next_flags;

	// Returns the status byte with reserved bits at zero.
	function automatic logic [7:0] status_byte(input flags_s f, input logic edge_sel);
		logic [7:0] b;
		b = STATUS_RESET;
		b[WRAP_BIT] = f.wrap;
		b[PERIOD_OVF_BIT] = f.period_ovf;
		b[COMPARE_BIT] = f.compare;
		b[EXT_EDGE_BIT] = edge_sel;
		b[CAPTURE_BIT] = f.capture;
		return b;
	endfunction

	// Every request waits one cycle, then completes on the following edge.
	// The fixed wait lets the read data come from a register, never from the decode.
	assign waitrequest = (read | write) & ~ack;
	assign status_read = ack & read & (address == STATUS_OFFSET);
	assign status_write = ack & write & (address == STATUS_OFFSET);
	assign config_write = ack & write & (address == CONFIG_OFFSET);
	assign limit_write = ack & write & (address == LIMIT_OFFSET);
	assign counter_write = ack & write & (address == COUNTER_OFFSET) & ~cfg.speed_mode;

	// Acknowledge and read data are prepared in the waiting cycle.
	always_comb begin
		next_ack = (read | write) & ~ack;
		next_readdata = readdata;
		if (read & ~ack) begin
			unique case (address)
				STATUS_OFFSET: next_readdata = {24'h00_0000, status_byte(flags,
					ext_clock_edge_select)};
				CONFIG_OFFSET: next_readdata = {25'h000_0000, cfg};
				LIMIT_OFFSET: next_readdata = {16'h0000, cycle_limit_register};
				CAPTURE_OFFSET: next_readdata = {16'h0000, capture_register};
				COUNTER_OFFSET: next_readdata = {16'h0000, period_counter};
				default: next_readdata = 32'h0000_0000;
			endcase
		end
	end

	// Register the handshake and read data.
	always_ff @(posedge clk) begin
		if (reset) begin
			ack <= 1'b0;
			readdata <= 32'h0000_0000;
		end else begin
			ack <= next_ack;
			readdata <= next_readdata;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Software registers.

	// Configuration, limit and external edge select take bus writes.
	always_comb begin
		next_cfg = cfg;
		next_cycle_limit_register = cycle_limit_register;
		next_ext_clock_edge_select = ext_clock_edge_select;
		if (config_write) begin
			next_cfg.run = writedata[RUN_BIT];
			next_cfg.speed_mode = writedata[SPEED_MODE_BIT];
			next_cfg.event_edge_select = writedata[EVENT_EDGE_BIT];
			next_cfg.event_polarity_invert = writedata[POLARITY_BIT];
			next_cfg.clock_select = writedata[CLOCK_SEL_LSB +: 3];
		end
		if (limit_write) begin
			next_cycle_limit_register = writedata[15:0];
		end
		if (status_write) begin
			next_ext_clock_edge_select = writedata[EXT_EDGE_BIT];
		end
	end

	// Register the software settings.
	always_ff @(posedge clk) begin
		if (reset) begin
			cfg <= '0;
			cycle_limit_register <= LIMIT_RESET;
			ext_clock_edge_select <= 1'b0;
		end else begin
			cfg <= next_cfg;
			cycle_limit_register <= next_cycle_limit_register;
			ext_clock_edge_select <= next_ext_clock_edge_select;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Counting and capture.

	logic count_edge;
	logic event_edge;
	logic count_step;
	logic capture_now;
	logic restart_count;
	logic [15:0] next_period_counter;
	logic [15:0] next_capture_register;
	meas_state_e meas_state;
	meas_state_e next_meas_state;

	// External clock edge chosen by the edge select bit; otherwise the prescaler.
	assign count_edge = (cfg.clock_select == CLOCK_SEL_EXTERNAL) ?
		(ext_clock_edge_select ? ext_rise : ext_fall) : prescale_tick;

	// Event edge follows the edge select, swapped by polarity inversion.
	assign event_edge = (cfg.event_edge_select ^ cfg.event_polarity_invert) ?
		event_fall : event_rise;

	// The counter runs in timer mode when started, and during a period in speed mode.
	assign count_step = count_edge & (cfg.speed_mode ? (meas_state != meas_idle) : cfg.run);

	// Capture on every event edge in timer mode while running, on the third edge in speed mode.
	always_comb begin
		next_meas_state = meas_state;
		capture_now = 1'b0;
		restart_count = 1'b0;
		if (!cfg.speed_mode) begin
			next_meas_state = meas_idle;
			capture_now = event_edge & cfg.run;
		end else if (event_edge) begin
			unique case (meas_state)
				meas_idle: begin
					next_meas_state = meas_first;
					restart_count = 1'b1;
				end
				meas_first: begin
					next_meas_state = meas_second;
				end
				meas_second: begin
					next_meas_state = meas_first;
					capture_now = 1'b1;
					restart_count = 1'b1;
				end
			endcase
		end
	end

	// Counter and capture register updates.
	always_comb begin
		next_period_counter = period_counter;
		next_capture_register = capture_register;
		if (capture_now) begin
			next_capture_register = period_counter;
		end
		if (!cfg.speed_mode && !cfg.run) begin
			next_period_counter = COUNT_RESET;
		end else if (restart_count) begin
			next_period_counter = COUNT_RESET;
		end else if (count_step) begin
			next_period_counter = period_counter + 16'h0001;
		end
		if (counter_write) begin
			next_period_counter = writedata[15:0];
		end
	end

	// Register the counting state.
	always_ff @(posedge clk) begin
		if (reset) begin
			meas_state <= meas_idle;
			period_counter <= COUNT_RESET;
			capture_register <= COUNT_RESET;
		end else begin
			meas_state <= next_meas_state;
			period_counter <= next_period_counter;
			capture_register <= next_capture_register;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Sticky status flags.

	flags_s set_event;
	flags_s clear_ok;

	// Flag set conditions from the counting logic.
	always_comb begin
		set_event.wrap = count_step & ~restart_count & ~counter_write &
			(period_counter == COUNT_MAX);
		set_event.period_ovf = cfg.speed_mode & capture_now &
			(period_counter > cycle_limit_register);
		set_event.compare = ~cfg.speed_mode &
			(period_counter == cycle_limit_register);
		set_event.capture = capture_now;
	end

	// A write of 0 clears only a flag armed by a read that saw it as 1.
	always_comb begin
		clear_ok.wrap = status_write & armed.wrap & ~writedata[WRAP_BIT];
		clear_ok.period_ovf = status_write & armed.period_ovf &
			~writedata[PERIOD_OVF_BIT];
		clear_ok.compare = status_write & armed.compare & ~writedata[COMPARE_BIT];
		clear_ok.capture = status_write & armed.capture & ~writedata[CAPTURE_BIT];
	end

	// Arming follows status reads; any status write ends it. Set wins over clear.
	// A read arms only the flags that its returned byte showed as 1. A flag that
	// rises while the read is waiting was never seen by software, so a following
	// write of 0 must leave it alone.
	always_comb begin
		next_armed = armed;
		if (status_write) begin
			next_armed = '0;
		end else if (status_read) begin
			next_armed.wrap = readdata[WRAP_BIT];
			next_armed.period_ovf = readdata[PERIOD_OVF_BIT];
			next_armed.compare = readdata[COMPARE_BIT];
			next_armed.capture = readdata[CAPTURE_BIT];
		end
		next_flags = (flags & ~clear_ok) | set_event;
	end

	// Register the flags and their arming.
	always_ff @(posedge clk) begin
		if (reset) begin
			flags <= '0;
			armed <= '0;
		end else begin
			flags <= next_flags;
			armed <= next_armed;
		end
	end

endmodule
`default_nettype wire

// file: verilog/pin_edge_detect.sv
// Synchroniser and edge detector for one asynchronous input pin.
// Assumes the pin is slow against the system clock; pulses are one cycle.
`timescale 1ns/1ns
`default_nettype none
module pin_edge_detect (
	// Clock and reset.
	input wire logic clk,
	input wire logic reset,
	// Pin from outside the clock domain.
	input wire logic pin,
	// One-cycle edge pulses.
	output logic rise,
	output logic fall
);

	logic meta;
	logic sync;
	logic last;
	logic next_meta;
	logic next_sync;
	logic next_last;

	// The first stage feeds only the second stage.
	always_comb begin
		next_meta = pin;
		next_sync = meta;
		next_last = sync;
	end

	// Register the synchroniser and the history stage.
	always_ff @(posedge clk) begin
		if (reset) begin
			meta <= 1'b0;
			sync <= 1'b0;
			last <= 1'b0;
		end else begin
			meta <= next_meta;
			sync <= next_sync;
			last <= next_last;
		end
	end

	assign rise = sync & ~last;
	assign fall = ~sync & last;

endmodule
`default_nettype wire
